// >>> hw/mfm_regs.sv
// main-domain event summary and mode control registers
// assumes a frame decoder outside checks crc and address, then drives
// one-cycle strobes with a 16-bit word holding frame bits 23..8
//
// What this block does
// RL1 - comm error summary bit 23 is crc flag or request flag or safety summary
// RL2 - wake summary bit 22 is or of both latched wake flags
// RL3 - prereg summary bit 21 is or of its four fault flags
// RL4 - core buck summary bit 19 is or of overcurrent and overtemp
// RL5 - aux buck summary bit 17 is or of overcurrent and overtemp
// RL6 - linear reg summary bit 16 is or of overcurrent and overtemp
// RL7 - summary bits are unstored and clear once all sources clear
// RL8 - crc flag bit 9 sets on bad crc, clears by reset or writing one
// RL9 - request flag bit 8 sets on bad access, clears by writing one
// RL10 - mode reads lock, clock source, normal, wake disables; takes clock/standby
// RL11 - writing one to standby bit requests standby, zero does nothing
// RL12 - a set wake disable bit blocks that wake input from waking
// RL13 - writing one to clock disable deselects external clock, zero nothing
// RL14 - normal bit reads one only while main state machine is normal
// RL15 - writes to read-only and reserved bits ignored, reserved read zero
`timescale 1ns/10ps
`include "mfm_consts.svh"

module mfm_regs (
	input  wire logic               sys_clk,
	input  wire logic               rstn,
	input  wire mfm_pkg::mfm_reg_t  reg_sel,
	input  wire logic               wr_stb,
	input  wire mfm_pkg::mfm_word_t wr_data,
	input  wire logic               rd_stb,
	output mfm_pkg::mfm_word_t      rd_data,
	output logic                    rd_valid,
	input  wire logic               crc_err_evt,
	input  wire logic               bad_frame_evt,
	input  wire logic               bad_addr_evt,
	input  wire logic               init_write_evt,
	input  wire logic               wake_in_a_flag,
	input  wire logic               wake_in_b_flag,
	input  wire logic               prereg_overcurrent,
	input  wire logic               prereg_undervolt_high,
	input  wire logic               prereg_undervolt_low,
	input  wire logic               prereg_feedback_overvolt,
	input  wire logic               core_buck_overcurrent,
	input  wire logic               core_buck_overtemp,
	input  wire logic               aux_buck_overcurrent,
	input  wire logic               aux_buck_overtemp,
	input  wire logic               linear_reg_overcurrent,
	input  wire logic               linear_reg_overtemp,
	input  wire logic               safety_comm_summary,
	input  wire logic               pll_lock_status,
	input  wire logic               ext_clock_selected_status,
	input  wire logic               main_state_normal,
	input  wire logic               wake_a_event,
	input  wire logic               wake_b_event,
	output logic                    wake_a_wakeup,
	output logic                    wake_b_wakeup,
	output logic                    wake_a_disable,
	output logic                    wake_b_disable,
	output logic                    ext_clock_disable_req,
	output logic                    standby_request
);
	import mfm_pkg::*;

	mfm_flags_if flg ();

	logic       crc_flag;
	logic       req_flag;
	logic       norm_stat;
	logic       next_crc_flag;
	logic       next_req_flag;
	logic       next_norm_stat;
	logic       next_wake_a_disable;
	logic       next_wake_b_disable;
	logic       next_ext_clock_disable_req;
	logic       next_standby_request;
	mfm_word_t  next_rd_data;
	logic       next_rd_valid;
	mfm_word_t  mode_word;
	logic       wr_sum;
	logic       wr_mode;

	// flags go to the summary builder through the carrier
	assign flg.wake_in_a_flag           = wake_in_a_flag;
	assign flg.wake_in_b_flag           = wake_in_b_flag;
	assign flg.prereg_overcurrent       = prereg_overcurrent;
	assign flg.prereg_undervolt_high    = prereg_undervolt_high;
	assign flg.prereg_undervolt_low     = prereg_undervolt_low;
	assign flg.prereg_feedback_overvolt = prereg_feedback_overvolt;
	assign flg.core_buck_overcurrent    = core_buck_overcurrent;
	assign flg.core_buck_overtemp       = core_buck_overtemp;
	assign flg.aux_buck_overcurrent     = aux_buck_overcurrent;
	assign flg.aux_buck_overtemp        = aux_buck_overtemp;
	assign flg.linear_reg_overcurrent   = linear_reg_overcurrent;
	assign flg.linear_reg_overtemp      = linear_reg_overtemp;
	assign flg.safety_comm_summary      = safety_comm_summary;
	assign flg.crc_err_flag             = crc_flag;
	assign flg.req_err_flag             = req_flag;

	mfm_summary u_summary (
		.flg (flg.calc)
	);

	assign wr_sum  = wr_stb && (reg_sel == MFM_REG_SUMMARY);
	assign wr_mode = wr_stb && (reg_sel == MFM_REG_MODE);

	// RL12 wake gating
	assign wake_a_wakeup = wake_a_event & ~wake_a_disable;
	assign wake_b_wakeup = wake_b_event & ~wake_b_disable;

	// mode read value, reserved bits stay zero
	always_comb begin
		mode_word = '0;
		// RL10 mode readback
		mode_word[mfm_idx(`MFM_MODE_PLL)]     = pll_lock_status;
		mode_word[mfm_idx(`MFM_MODE_EXT_SEL)] = ext_clock_selected_status;
		mode_word[mfm_idx(`MFM_MODE_NORM)]    = norm_stat;
		mode_word[mfm_idx(`MFM_MODE_WB_DIS)]  = wake_b_disable;
		mode_word[mfm_idx(`MFM_MODE_WA_DIS)]  = wake_a_disable;
	end

	// next state of flags, controls and read port; a set beats a same-cycle clear
	always_comb begin
		// RL8 crc flag w1c
		next_crc_flag = crc_err_evt
			| (crc_flag & ~(wr_sum & wr_data[mfm_idx(`MFM_SUM_CRC)]));
		// RL9 request flag w1c
		next_req_flag = bad_frame_evt | bad_addr_evt | (init_write_evt & norm_stat)
			| (req_flag & ~(wr_sum & wr_data[mfm_idx(`MFM_SUM_REQ)]));
		// RL14 normal status
		next_norm_stat = main_state_normal;
		// RL15 only writable bits taken
		next_wake_a_disable = wr_mode ? wr_data[mfm_idx(`MFM_MODE_WA_DIS)] : wake_a_disable;
		next_wake_b_disable = wr_mode ? wr_data[mfm_idx(`MFM_MODE_WB_DIS)] : wake_b_disable;
		// RL13 clock disable pulse
		next_ext_clock_disable_req = wr_mode & wr_data[mfm_idx(`MFM_MODE_EXT_DIS)];
		// RL11 standby pulse
		next_standby_request = wr_mode & wr_data[mfm_idx(`MFM_MODE_STBY)];
		next_rd_valid = rd_stb;
		next_rd_data  = rd_data;
		if (rd_stb) begin
			case (reg_sel)
				MFM_REG_SUMMARY: next_rd_data = flg.summary_word;
				MFM_REG_MODE:    next_rd_data = mode_word;
				default:         next_rd_data = '0;
			endcase
		end
	end

	// standby and clock disable are one-shot requests, never read back
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			crc_flag              <= `MFM_FLAG_RESET;
			req_flag              <= `MFM_FLAG_RESET;
			norm_stat             <= `MFM_NORM_RESET;
			wake_a_disable        <= `MFM_DIS_RESET;
			wake_b_disable        <= `MFM_DIS_RESET;
			ext_clock_disable_req <= 1'b0;
			standby_request       <= 1'b0;
			rd_data               <= '0;
			rd_valid              <= 1'b0;
		end else begin
			crc_flag              <= next_crc_flag;
			req_flag              <= next_req_flag;
			norm_stat             <= next_norm_stat;
			wake_a_disable        <= next_wake_a_disable;
			wake_b_disable        <= next_wake_b_disable;
			ext_clock_disable_req <= next_ext_clock_disable_req;
			standby_request       <= next_standby_request;
			rd_data               <= next_rd_data;
			rd_valid              <= next_rd_valid;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	AST_COM_SUM: assert property (rd_stb && reg_sel == MFM_REG_SUMMARY |=> // RL1
		rd_valid && rd_data[mfm_idx(`MFM_SUM_COM)] ==
		($past(crc_flag) | $past(req_flag) | $past(safety_comm_summary)))
		else $error("comm summary wrong");
	AST_WAKE_SUM: assert property (rd_stb && reg_sel == MFM_REG_SUMMARY |=> // RL2
		rd_data[mfm_idx(`MFM_SUM_WAKE)] == ($past(wake_in_a_flag) | $past(wake_in_b_flag)))
		else $error("wake summary wrong");
	AST_PRE_SUM: assert property (rd_stb && reg_sel == MFM_REG_SUMMARY && !prereg_overcurrent // RL3
		&& !prereg_undervolt_high && !prereg_undervolt_low && !prereg_feedback_overvolt
		|=> !rd_data[mfm_idx(`MFM_SUM_PRE)])
		else $error("prereg summary stuck");
	AST_CORE_SUM: assert property (rd_stb && reg_sel == MFM_REG_SUMMARY && core_buck_overtemp // RL4
		|=> rd_data[mfm_idx(`MFM_SUM_CORE)])
		else $error("core buck summary missed");
	AST_AUX_SUM: assert property (rd_stb && reg_sel == MFM_REG_SUMMARY && aux_buck_overcurrent // RL5
		|=> rd_data[mfm_idx(`MFM_SUM_AUX)])
		else $error("aux buck summary missed");
	AST_LIN_SUM: assert property (rd_stb && reg_sel == MFM_REG_SUMMARY // RL6
		|=> rd_data[mfm_idx(`MFM_SUM_LIN)] ==
		($past(linear_reg_overcurrent) | $past(linear_reg_overtemp)))
		else $error("linear summary wrong");
	AST_CRC_SET: assert property (crc_err_evt |=> crc_flag) // RL8
		else $error("crc flag not set");
	AST_CRC_CLR: assert property (wr_sum && wr_data[mfm_idx(`MFM_SUM_CRC)] && !crc_err_evt // RL8
		|=> !crc_flag)
		else $error("crc flag not cleared");
	AST_REQ_SET: assert property ((bad_frame_evt || bad_addr_evt) |=> req_flag) // RL9
		else $error("request flag not set");
	AST_REQ_INIT: assert property (init_write_evt && !norm_stat && !bad_frame_evt // RL9
		&& !bad_addr_evt && !req_flag |=> !req_flag)
		else $error("init write flagged outside normal");
	AST_STBY: assert property (wr_mode && wr_data[mfm_idx(`MFM_MODE_STBY)] // RL11
		|=> standby_request ##1 !standby_request || $past(wr_mode))
		else $error("standby request not one pulse");
	AST_WAKE_GATE: assert property (wake_a_disable |-> !wake_a_wakeup) // RL12
		else $error("disabled wake input woke device");
	AST_EXT_DIS: assert property (wr_mode && !wr_data[mfm_idx(`MFM_MODE_EXT_DIS)] // RL13
		|=> !ext_clock_disable_req)
		else $error("clock disable fired on zero");
	AST_EXT_SET: assert property (wr_mode && wr_data[mfm_idx(`MFM_MODE_EXT_DIS)] // RL13
		|=> ext_clock_disable_req)
		else $error("clock disable request missed");
	AST_NORM: assert property (rd_stb && reg_sel == MFM_REG_MODE ##1 1'b1 |-> // RL14
		rd_data[mfm_idx(`MFM_MODE_NORM)] == $past(norm_stat))
		else $error("normal status misread");
	// the mask depends on which register the answered read selected
	AST_RSV: assert property (rd_valid |-> (rd_data & (($past(reg_sel) == MFM_REG_MODE) // RL15
		? `MFM_MODE_RSV_MASK : `MFM_SUM_RSV_MASK)) == 16'h0000)
		else $error("reserved bits not zero");
endmodule : mfm_regs

// >>> common/mfm_consts.svh
// bit positions, reset values and reserved read masks of the main flag/mode bank
// assumes register words carry bits 23..8 of the frame in bits 15..0
`ifndef MFM_CONSTS_SVH
`define MFM_CONSTS_SVH

`define MFM_BIT_BASE      8
`define MFM_WORD_W        16

`define MFM_SUM_COM       23
`define MFM_SUM_WAKE      22
`define MFM_SUM_PRE       21
`define MFM_SUM_CORE      19
`define MFM_SUM_AUX       17
`define MFM_SUM_LIN       16
`define MFM_SUM_CRC       9
`define MFM_SUM_REQ       8

`define MFM_MODE_PLL      16
`define MFM_MODE_EXT_SEL  15
`define MFM_MODE_EXT_DIS  14
`define MFM_MODE_NORM     13
`define MFM_MODE_WB_DIS   10
`define MFM_MODE_WA_DIS   9
`define MFM_MODE_STBY     8

`define MFM_NORM_RESET    1'b1
`define MFM_FLAG_RESET    1'b0
`define MFM_DIS_RESET     1'b0

// reserved read positions of each word, these must always read back zero
`define MFM_SUM_RSV_MASK  16'h14fc
`define MFM_MODE_RSV_MASK 16'hfe59

`endif

// >>> common/mfm_pkg.sv
// types and helpers shared by the main flag/mode bank
// assumes mfm_consts.svh is on the include path
`include "mfm_consts.svh"

package mfm_pkg;
	// register select driven by the frame decoder
	typedef enum logic {MFM_REG_SUMMARY, MFM_REG_MODE} mfm_reg_t;
	typedef logic [`MFM_WORD_W-1:0] mfm_word_t;

	// frame bit number to word index
	function automatic logic [3:0] mfm_idx(input int unsigned pos);
		return 4'(pos - `MFM_BIT_BASE);
	endfunction : mfm_idx
endpackage : mfm_pkg

// >>> common/mfm_flags_if.sv
// individual flags into the summary builder, summary word back out
// assumes mfm_pkg is compiled first
`timescale 1ns/10ps

interface mfm_flags_if;
	logic                wake_in_a_flag;
	logic                wake_in_b_flag;
	logic                prereg_overcurrent;
	logic                prereg_undervolt_high;
	logic                prereg_undervolt_low;
	logic                prereg_feedback_overvolt;
	logic                core_buck_overcurrent;
	logic                core_buck_overtemp;
	logic                aux_buck_overcurrent;
	logic                aux_buck_overtemp;
	logic                linear_reg_overcurrent;
	logic                linear_reg_overtemp;
	logic                safety_comm_summary;
	logic                crc_err_flag;
	logic                req_err_flag;
	mfm_pkg::mfm_word_t  summary_word;

	modport src (output wake_in_a_flag, wake_in_b_flag, prereg_overcurrent,
		prereg_undervolt_high, prereg_undervolt_low, prereg_feedback_overvolt,
		core_buck_overcurrent, core_buck_overtemp, aux_buck_overcurrent,
		aux_buck_overtemp, linear_reg_overcurrent, linear_reg_overtemp,
		safety_comm_summary, crc_err_flag, req_err_flag, input summary_word);
	modport calc (input wake_in_a_flag, wake_in_b_flag, prereg_overcurrent,
		prereg_undervolt_high, prereg_undervolt_low, prereg_feedback_overvolt,
		core_buck_overcurrent, core_buck_overtemp, aux_buck_overcurrent,
		aux_buck_overtemp, linear_reg_overcurrent, linear_reg_overtemp,
		safety_comm_summary, crc_err_flag, req_err_flag, output summary_word);
endinterface : mfm_flags_if

// >>> hw/mfm_summary.sv
// builds the read value of the event summary register from live flags
// assumes flags arrive already latched by their own flag registers
`timescale 1ns/10ps
`include "mfm_consts.svh"

module mfm_summary (
	mfm_flags_if.calc  flg
);
	import mfm_pkg::*;

	// group bits are pure ors, nothing stored, so they drop with the last source
	always_comb begin
		flg.summary_word = '0;
		// RL1 comm error or
		flg.summary_word[mfm_idx(`MFM_SUM_COM)] = flg.crc_err_flag | flg.req_err_flag
			| flg.safety_comm_summary;
		// RL2 wake or
		flg.summary_word[mfm_idx(`MFM_SUM_WAKE)] = flg.wake_in_a_flag | flg.wake_in_b_flag;
		// RL3 prereg or
		flg.summary_word[mfm_idx(`MFM_SUM_PRE)] = flg.prereg_overcurrent
			| flg.prereg_undervolt_high | flg.prereg_undervolt_low
			| flg.prereg_feedback_overvolt;
		// RL4 core buck or
		flg.summary_word[mfm_idx(`MFM_SUM_CORE)] = flg.core_buck_overcurrent
			| flg.core_buck_overtemp;
		// RL5 aux buck or
		flg.summary_word[mfm_idx(`MFM_SUM_AUX)] = flg.aux_buck_overcurrent
			| flg.aux_buck_overtemp;
		// RL6 linear reg or
		flg.summary_word[mfm_idx(`MFM_SUM_LIN)] = flg.linear_reg_overcurrent
			| flg.linear_reg_overtemp;
		// RL8 RL9 latched crc and request flags
		flg.summary_word[mfm_idx(`MFM_SUM_CRC)] = flg.crc_err_flag;
		flg.summary_word[mfm_idx(`MFM_SUM_REQ)] = flg.req_err_flag;
	end
endmodule : mfm_summary

// >>> tb/mfm_host_model.sv
// host-side access model: issues register strobes as the frame decoder would
// assumes the bench drives every other design input on the falling edge
`timescale 1ns/10ps

module mfm_host_model (
	input  wire logic               sys_clk,
	output mfm_pkg::mfm_reg_t       reg_sel,
	output logic                    wr_stb,
	output mfm_pkg::mfm_word_t      wr_data,
	output logic                    rd_stb,
	input  wire mfm_pkg::mfm_word_t rd_data,
	input  wire logic               rd_valid
);
	import mfm_pkg::*;

	// idle bus until the first access
	initial begin
		reg_sel = MFM_REG_SUMMARY;
		wr_stb  = 1'b0;
		wr_data = 16'h0000;
		rd_stb  = 1'b0;
	end

	task automatic write(input mfm_reg_t sel, input mfm_word_t data);
		@(negedge sys_clk);
		reg_sel = sel;
		wr_data = data;
		wr_stb  = 1'b1;
		@(negedge sys_clk);
		wr_stb  = 1'b0;
		wr_data = ~data; // stale data must not look valid
	endtask : write

	// one-cycle read strobe, answer awaited under a bound
	task automatic read(input mfm_reg_t sel, output mfm_word_t data, output logic ok);
		int n;
		@(negedge sys_clk);
		reg_sel = sel;
		rd_stb  = 1'b1;
		@(negedge sys_clk);
		rd_stb  = 1'b0;
		n = 0;
		while (rd_valid !== 1'b1 && n < 4) begin
			@(negedge sys_clk);
			n++;
		end
		ok   = (rd_valid === 1'b1);
		data = rd_data;
	endtask : read
endmodule : mfm_host_model

// >>> tb/main_flag_and_mode_registers_tb.sv
// self-checking bench for the main flag/mode register bank
// assumes the host model and the design files are compiled first
`timescale 1ns/10ps

module main_flag_and_mode_registers_tb;
	import mfm_pkg::*;

	logic        sys_clk = 1'b0;
	logic        rstn;
	mfm_reg_t    reg_sel;
	logic        wr_stb, rd_stb, rd_valid;
	mfm_word_t   wr_data, rd_data;
	logic [12:0] fl;
	logic [3:0]  ev;
	logic        pll, ext_sel, norm, wk_a, wk_b;
	logic        wa_up, wb_up, wa_dis, wb_dis, ext_dis, stby;
	int          bad_count, total_checks, cyc;
	// word index of the group bit fed by each flag
	localparam int sum_pos [13] = '{14, 14, 13, 13, 13, 13, 11, 11, 9, 9, 8, 8, 15};

	always #2.5 sys_clk = ~sys_clk;

	mfm_host_model mfm_host_model_i (.sys_clk(sys_clk), .reg_sel(reg_sel), .wr_stb(wr_stb),
		.wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid));

	mfm_regs mfm_regs_i (.sys_clk(sys_clk), .rstn(rstn), .reg_sel(reg_sel), .wr_stb(wr_stb),
		.wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid),
		.crc_err_evt(ev[0]), .bad_frame_evt(ev[1]), .bad_addr_evt(ev[2]),
		.init_write_evt(ev[3]), .wake_in_a_flag(fl[0]), .wake_in_b_flag(fl[1]),
		.prereg_overcurrent(fl[2]), .prereg_undervolt_high(fl[3]),
		.prereg_undervolt_low(fl[4]), .prereg_feedback_overvolt(fl[5]),
		.core_buck_overcurrent(fl[6]), .core_buck_overtemp(fl[7]),
		.aux_buck_overcurrent(fl[8]), .aux_buck_overtemp(fl[9]),
		.linear_reg_overcurrent(fl[10]), .linear_reg_overtemp(fl[11]),
		.safety_comm_summary(fl[12]), .pll_lock_status(pll),
		.ext_clock_selected_status(ext_sel), .main_state_normal(norm),
		.wake_a_event(wk_a), .wake_b_event(wk_b), .wake_a_wakeup(wa_up),
		.wake_b_wakeup(wb_up), .wake_a_disable(wa_dis), .wake_b_disable(wb_dis),
		.ext_clock_disable_req(ext_dis), .standby_request(stby));

	// verdict and end of run, reached from the main sequence or the timeout
	task automatic summarize();
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input mfm_word_t got, input mfm_word_t exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// a missing answer is forced into a mismatch
	task automatic rdchk(input mfm_reg_t sel, input mfm_word_t exp);
		mfm_word_t d;
		logic      ok;
		mfm_host_model_i.read(sel, d, ok);
		if (ok !== 1'b1)
			d = ~exp;
		chk(d, exp);
	endtask : rdchk

	task automatic pulse_ev(input int k);
		@(negedge sys_clk);
		ev[k] = 1'b1;
		@(negedge sys_clk);
		ev[k] = 1'b0;
	endtask : pulse_ev

	// hang guard: the sequence needs about 110 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		{fl, ev, pll, ext_sel, wk_a, wk_b} = '0;
		norm = 1'b1;
		rstn = 1'b0;
		repeat (4) @(negedge sys_clk);
		rstn = 1'b1;
		rdchk(MFM_REG_SUMMARY, 16'h0000);
		rdchk(MFM_REG_MODE, 16'h0020);
		foreach (sum_pos[i]) begin
			fl = 13'h0001 << i;
			rdchk(MFM_REG_SUMMARY, 16'h0001 << sum_pos[i]);
		end
		fl = 13'h1fff;
		rdchk(MFM_REG_SUMMARY, 16'heb00);
		// group stays until last source clears
		fl = 13'h0014;
		rdchk(MFM_REG_SUMMARY, 16'h2000);
		fl = 13'h0010;
		rdchk(MFM_REG_SUMMARY, 16'h2000);
		fl = 13'h0000;
		rdchk(MFM_REG_SUMMARY, 16'h0000);
		// crc flag set, survives zero, cleared by one
		pulse_ev(0);
		rdchk(MFM_REG_SUMMARY, 16'h8002);
		mfm_host_model_i.write(MFM_REG_SUMMARY, 16'hfffc);
		rdchk(MFM_REG_SUMMARY, 16'h8002);
		mfm_host_model_i.write(MFM_REG_SUMMARY, 16'h0002);
		rdchk(MFM_REG_SUMMARY, 16'h0000);
		// an event in the same cycle as the clear must win
		fork
			pulse_ev(0);
			mfm_host_model_i.write(MFM_REG_SUMMARY, 16'h0002);
		join
		rdchk(MFM_REG_SUMMARY, 16'h8002);
		mfm_host_model_i.write(MFM_REG_SUMMARY, 16'h0002);
		rdchk(MFM_REG_SUMMARY, 16'h0000);
		for (int k = 1; k < 4; k++) begin
			pulse_ev(k);
			rdchk(MFM_REG_SUMMARY, 16'h8001);
			mfm_host_model_i.write(MFM_REG_SUMMARY, 16'h0001);
			rdchk(MFM_REG_SUMMARY, 16'h0000);
		end
		norm = 1'b0;
		pulse_ev(3);
		rdchk(MFM_REG_SUMMARY, 16'h0000);
		{pll, ext_sel, wk_a, wk_b} = 4'hf;
		mfm_host_model_i.write(MFM_REG_MODE, 16'hffff);
		chk({14'h0000, stby, ext_dis}, 16'h0003);
		chk({12'h000, wa_dis, wb_dis, wa_up, wb_up}, 16'h000c);
		@(negedge sys_clk);
		chk({14'h0000, stby, ext_dis}, 16'h0000);
		rdchk(MFM_REG_MODE, 16'h0186);
		// standby alone and one wake disable alone, so swapped bits show up
		mfm_host_model_i.write(MFM_REG_MODE, 16'h0003);
		chk({12'h000, stby, ext_dis, wa_dis, wb_dis}, 16'h000a);
		chk({14'h0000, wa_up, wb_up}, 16'h0001);
		mfm_host_model_i.write(MFM_REG_MODE, 16'h0000);
		chk({12'h000, stby, ext_dis, wa_dis, wb_dis}, 16'h0000);
		chk({14'h0000, wa_up, wb_up}, 16'h0003);
		norm = 1'b1;
		rdchk(MFM_REG_MODE, 16'h01a0);
		// a mid-run reset drops the crc flag and both disables
		pulse_ev(0);
		mfm_host_model_i.write(MFM_REG_MODE, 16'h0006);
		@(negedge sys_clk);
		rstn = 1'b0;
		@(negedge sys_clk);
		rstn = 1'b1;
		chk({14'h0000, wa_dis, wb_dis}, 16'h0000);
		rdchk(MFM_REG_SUMMARY, 16'h0000);
		rdchk(MFM_REG_MODE, 16'h01a0);
		summarize();
	end
endmodule : main_flag_and_mode_registers_tb
